// [shared/dsr_pkg.sv]
// package: command codes, status field positions and reset values
package dsr_pkg;
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_SOFT_RESET = 8'h01;
    localparam logic [7:0] CMD_READ_IDENT = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h09;
    localparam logic [7:0] CMD_READ_POWER = 8'h0A;
    localparam logic [7:0] CMD_READ_ACCESS = 8'h0B;
    localparam logic [7:0] CMD_READ_PIXFMT = 8'h0C;
    localparam logic [2:0] NUM_IDENT_BYTES = 3'h3;
    localparam logic [2:0] NUM_STATUS_BYTES = 3'h4;
    localparam logic [2:0] NUM_SINGLE_BYTES = 3'h1;
    localparam logic [7:0] ACCESS_RESET = 8'h00;
    localparam logic [2:0] PIXFMT_RESET = 3'h7;
    localparam logic [2:0] PIXFMT_PARALLEL = 3'h7;
    localparam logic [2:0] PIXFMT_COMMAND = 3'h0;
    localparam logic [2:0] GAMMA_RESET = 3'h0;
    localparam int UPDATE_TIME_US = 5000;
    localparam int CLK_MHZ = 125;
    localparam int UPDATE_CYCLES = UPDATE_TIME_US * CLK_MHZ;
    // status word bit positions
    localparam int ST_BOOSTER = 31;
    localparam int ST_ACCESS_LO = 23;
    localparam int ST_PIXFMT_LO = 20;
    localparam int ST_IDLE = 19;
    localparam int ST_PARTIAL = 18;
    localparam int ST_SLEEP_OUT = 17;
    localparam int ST_NORMAL = 16;
    localparam int ST_VSCROLL = 15;
    localparam int ST_HSCROLL = 14;
    localparam int ST_INVERT = 13;
    localparam int ST_ALL_ON = 12;
    localparam int ST_ALL_OFF = 11;
    localparam int ST_DISP_ON = 10;
    localparam int ST_TEAR_ON = 9;
    localparam int ST_GAMMA_LO = 6;
    localparam int ST_TEAR_MODE = 5;
    localparam int ST_HSYNC = 4;
    localparam int ST_VSYNC = 3;
    localparam int ST_PCLK = 2;
    localparam int ST_PARITY = 0;
    typedef enum {DSR_IDLE, DSR_READ, DSR_BUSY} dsr_state_t;
endpackage : dsr_pkg

// [shared/dsr_reply_if.sv]
// interface: reply word and byte count between decoder and byte serialiser
`timescale 1ns/10ps
interface dsr_reply_if;
    logic load;
    logic [31:0] word;
    logic [2:0] count;
    logic pop;
    logic [7:0] data;
    logic busy;
    modport src (output load, output word, output count, output pop, input data, input busy);
    modport ser (input load, input word, input count, input pop, output data, output busy);
endinterface : dsr_reply_if

// [design/dsr_byte_serialiser.sv]
// byte serialiser: hands out reply word bytes, most significant first
`timescale 1ns/10ps
module dsr_byte_serialiser (
    input wire logic clk_sys, // system clock
    input wire logic reset, // synchronous reset
    dsr_reply_if.ser rep // reply channel
);
    logic [31:0] word_q;
    logic [2:0] left_q;
    wire logic take_next = rep.pop && (left_q != 3'h0);
    // left-justify so the first byte always sits in the top lane
    wire logic [31:0] aligned = rep.word << (6'(3'h4 - rep.count) * 6'h08);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            word_q <= 32'h0000_0000;
            left_q <= 3'h0;
        end
        else if (rep.load)
        begin
            word_q <= aligned;
            left_q <= rep.count;
        end
        else if (take_next)
        begin
            word_q <= {word_q[23:0], 8'h00};
            left_q <= left_q - 3'h1;
        end
    end

    assign rep.data = word_q[31:24];
    assign rep.busy = left_q != 3'h0;

    count_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
        take_next && !rep.load |=> left_q == $past(left_q) - 3'h1)
        else $error("byte count did not drop on a read cycle");
endmodule : dsr_byte_serialiser

// [design/dsr_sw_reset_timer.sv]
// timer: holds the register update window after a software reset
`timescale 1ns/10ps
module dsr_sw_reset_timer #(
    parameter int CYCLES = dsr_pkg::UPDATE_CYCLES
) (
    input wire logic clk_sys, // system clock
    input wire logic reset, // synchronous reset
    input wire logic start, // soft reset accepted
    output logic active // update window open
);
    logic [31:0] count_q;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            count_q <= 32'h0000_0000;
        else if (start)
            count_q <= 32'(CYCLES);
        else if (count_q != 32'h0000_0000)
            count_q <= count_q - 32'h0000_0001;
    end

    assign active = count_q != 32'h0000_0000;

    window_len_a: assert property (@(posedge clk_sys) disable iff (reset)
        start |=> active [*8])
        else $error("update window closed too early");
endmodule : dsr_sw_reset_timer

// [design/dsr_command_decoder.sv]
// command decoder for basic control and status read commands
// Operation
// - command 00h changes no state; it only ends a memory transfer.
// - command 01h blanks display, reloads reset defaults, enters sleep-in.
// - software reset leaves frame memory contents untouched.
// - command 04h returns maker, version, then module identifier bytes.
// - status bit 31 shows booster on.
// - status bits 30..23 mirror access control bits 7..0.
// - status bits 19..16 give idle, partial, sleep-out, normal mode.
// - bit 15 is vertical scroll; bit 14 always zero.
// - bits 13..10 give inversion, all on, all off, display on.
// - bit 9 shows tearing output enabled.
// - bits 8..6 give selected gamma curve code.
// - bit 5 gives tearing output mode.
// - bits 4..2 sample hsync, vsync, pixel clock at command receipt.
// - bit 1 always zero; bit 0 shows link parity error.
// - command 0Ah returns idle, sleep-out, normal, display-on in one byte.
// - command 0Bh returns access control bits 7,6,3,1,0; others zero.
`timescale 1ns/10ps
module dsr_command_decoder #(
    parameter int UPDATE_CYCLES = dsr_pkg::UPDATE_CYCLES,
    parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter logic MODULE_TYPE = 1'b1,
    parameter logic [6:0] VERSION_ID = 7'h01, // arbitrary value
    parameter logic [7:0] MODULE_ID = 8'h3C // arbitrary value
) (
    input wire logic clk_sys, // system clock
    input wire logic reset, // synchronous reset
    input wire logic cmd_valid, // command byte strobe
    input wire logic [7:0] cmd_code, // command byte
    input wire logic rd_strobe, // host read cycle
    input wire logic booster_on, // booster running
    input wire logic idle_on, // idle mode
    input wire logic partial_on, // partial mode
    input wire logic sleep_out, // sleep-out mode
    input wire logic normal_on, // normal display mode
    input wire logic vscroll_on, // vertical scrolling
    input wire logic invert_on, // inversion
    input wire logic all_on, // all pixels on
    input wire logic all_off, // all pixels off
    input wire logic display_on, // display on
    input wire logic tear_on, // tearing output on
    input wire logic tear_mode, // tearing output mode
    input wire logic [2:0] gamma_sel, // gamma curve code
    input wire logic [7:0] access_ctrl, // stored access control byte
    input wire logic [2:0] pixel_fmt, // interface pixel format
    input wire logic hsync_in, // parallel hsync level
    input wire logic vsync_in, // parallel vsync level
    input wire logic parallel_pixel_clock, // parallel pixel clock level
    input wire logic parity_err, // link parity error seen
    output logic [7:0] rd_data, // parameter byte
    output logic rd_valid, // parameter byte pending
    output logic soft_reset_pulse, // reload defaults request
    output logic blank_display, // display forced blank
    output logic sleep_in_state, // forced sleep-in
    output logic updating, // registers being updated
    output logic transfer_end // ends memory transfer
);
    ////////////////////////////////////////////////////////////////////
    dsr_reply_if rep();
    dsr_pkg::dsr_state_t state_q, state_d;
    logic [7:0] rd_data_q;
    logic rd_valid_q, srst_q, blank_q, sleep_q, upd_q, tend_q;
    logic timer_active;

    ////////////////////////////////////////////////////////////////////
    wire logic is_nop = cmd_valid && cmd_code == dsr_pkg::CMD_NOP;
    wire logic is_srst = cmd_valid && cmd_code == dsr_pkg::CMD_SOFT_RESET;
    wire logic is_ident = cmd_valid && cmd_code == dsr_pkg::CMD_READ_IDENT;
    wire logic is_status = cmd_valid && cmd_code == dsr_pkg::CMD_READ_STATUS;
    wire logic is_power = cmd_valid && cmd_code == dsr_pkg::CMD_READ_POWER;
    wire logic is_access = cmd_valid && cmd_code == dsr_pkg::CMD_READ_ACCESS;
    wire logic is_pixfmt = cmd_valid && cmd_code == dsr_pkg::CMD_READ_PIXFMT;
    wire logic is_read = is_ident || is_status || is_power || is_access || is_pixfmt;

    // identification word, low three bytes used
    wire logic [31:0] ident_word = {8'h00, MAKER_ID, MODULE_TYPE, VERSION_ID, MODULE_ID};

    logic [31:0] status_word;
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[dsr_pkg::ST_BOOSTER] = booster_on;
        status_word[dsr_pkg::ST_ACCESS_LO +: 8] = access_ctrl;
        status_word[dsr_pkg::ST_PIXFMT_LO +: 3] = pixel_fmt;
        status_word[dsr_pkg::ST_IDLE] = idle_on;
        status_word[dsr_pkg::ST_PARTIAL] = partial_on;
        status_word[dsr_pkg::ST_SLEEP_OUT] = sleep_out && !sleep_q;
        status_word[dsr_pkg::ST_NORMAL] = normal_on;
        status_word[dsr_pkg::ST_VSCROLL] = vscroll_on;
        status_word[dsr_pkg::ST_INVERT] = invert_on;
        status_word[dsr_pkg::ST_ALL_ON] = all_on;
        status_word[dsr_pkg::ST_ALL_OFF] = all_off;
        status_word[dsr_pkg::ST_DISP_ON] = display_on && !blank_q;
        status_word[dsr_pkg::ST_TEAR_ON] = tear_on;
        status_word[dsr_pkg::ST_GAMMA_LO +: 3] = gamma_sel;
        status_word[dsr_pkg::ST_TEAR_MODE] = tear_mode;
        // line levels caught in the cycle the command arrives
        status_word[dsr_pkg::ST_HSYNC] = hsync_in;
        status_word[dsr_pkg::ST_VSYNC] = vsync_in;
        status_word[dsr_pkg::ST_PCLK] = parallel_pixel_clock;
        status_word[dsr_pkg::ST_PARITY] = parity_err;
    end

    wire logic [7:0] power_byte = {1'b0, idle_on, 1'b0, sleep_out && !sleep_q,
        normal_on, display_on && !blank_q, 2'b00};
    wire logic [7:0] access_byte = {access_ctrl[7:6], 2'b00, access_ctrl[3], 1'b0,
        access_ctrl[1:0]};
    wire logic [7:0] pixfmt_byte = {1'b0, dsr_pkg::PIXFMT_PARALLEL, 1'b0,
        dsr_pkg::PIXFMT_COMMAND};

    wire logic [31:0] reply_word = is_ident ? ident_word :
        is_status ? status_word :
        is_power ? {24'h00_0000, power_byte} :
        is_access ? {24'h00_0000, access_byte} :
        {24'h00_0000, pixfmt_byte};
    wire logic [2:0] reply_count = is_ident ? dsr_pkg::NUM_IDENT_BYTES :
        is_status ? dsr_pkg::NUM_STATUS_BYTES : dsr_pkg::NUM_SINGLE_BYTES;

    ////////////////////////////////////////////////////////////////////
    // a new read command while bytes remain discards the rest of the reply
    assign rep.load = is_read;
    assign rep.word = reply_word;
    assign rep.count = reply_count;
    assign rep.pop = rd_strobe && !is_read;

    dsr_byte_serialiser u_ser (
        .clk_sys(clk_sys),
        .reset(reset),
        .rep(rep)
    );

    dsr_sw_reset_timer #(.CYCLES(UPDATE_CYCLES)) u_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(is_srst),
        .active(timer_active)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            dsr_pkg::DSR_IDLE:
                if (is_srst)
                    state_d = dsr_pkg::DSR_BUSY;
                else if (is_read)
                    state_d = dsr_pkg::DSR_READ;
            dsr_pkg::DSR_READ:
                if (is_srst)
                    state_d = dsr_pkg::DSR_BUSY;
                else if (!rep.busy && !is_read)
                    state_d = dsr_pkg::DSR_IDLE;
            dsr_pkg::DSR_BUSY:
                if (!timer_active && !is_srst)
                    state_d = dsr_pkg::DSR_IDLE;
            default:
                state_d = dsr_pkg::DSR_IDLE;
        endcase
    end

    // blank and sleep stay forced until the host issues a command other than NOP, soft reset or a read
    wire logic clear_force = cmd_valid && !is_srst && !is_nop && !is_read;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_q <= dsr_pkg::DSR_IDLE;
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
            srst_q <= 1'b0;
            blank_q <= 1'b1;
            sleep_q <= 1'b1;
            upd_q <= 1'b0;
            tend_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            rd_data_q <= rep.busy ? rep.data : 8'h00;
            rd_valid_q <= rep.busy;
            // frame memory is not touched, only control registers reload
            srst_q <= is_srst;
            if (is_srst)
            begin
                blank_q <= 1'b1;
                sleep_q <= 1'b1;
            end
            else if (clear_force)
            begin
                blank_q <= 1'b0;
                sleep_q <= 1'b0;
            end
            upd_q <= timer_active;
            tend_q <= is_nop;
        end
    end

    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign soft_reset_pulse = srst_q;
    assign blank_display = blank_q;
    assign sleep_in_state = sleep_q;
    assign updating = upd_q;
    assign transfer_end = tend_q;

    ////////////////////////////////////////////////////////////////////
    nop_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
        is_nop |=> !srst_q && blank_q == $past(blank_q) && sleep_q == $past(sleep_q))
        else $error("no-operation changed state");
    srst_effect_a: assert property (@(posedge clk_sys) disable iff (reset)
        is_srst |=> srst_q && blank_q && sleep_q ##1 updating)
        else $error("soft reset did not blank and sleep");
    // first reply byte stands on the output from the first edge after the command, checked at the second
    ident_first_a: assert property (@(posedge clk_sys) disable iff (reset)
        is_ident |=> ##1 rd_valid && rd_data == MAKER_ID)
        else $error("first identification byte wrong");
    status_top_a: assert property (@(posedge clk_sys) disable iff (reset)
        is_status |=> ##1 rd_valid && rd_data[7] == $past(booster_on, 2))
        else $error("status top byte wrong");
    power_byte_a: assert property (@(posedge clk_sys) disable iff (reset)
        is_power |=> ##1 rd_valid && rd_data[7] == 1'b0 && rd_data[1:0] == 2'b00)
        else $error("power mode reserved bits set");
    access_byte_a: assert property (@(posedge clk_sys) disable iff (reset)
        is_access |=> ##1 rd_valid && rd_data[5:4] == 2'b00 && rd_data[2] == 1'b0)
        else $error("access control reserved bits set");
    pixfmt_byte_a: assert property (@(posedge clk_sys) disable iff (reset)
        is_pixfmt |=> ##1 rd_valid && rd_data == 8'h70)
        else $error("pixel format byte wrong");
    single_done_a: assert property (@(posedge clk_sys) disable iff (reset)
        is_power ##1 !cmd_valid ##1 (rd_strobe && !cmd_valid) |=> ##1 !rd_valid)
        else $error("single byte reply ran long");
endmodule : dsr_command_decoder

// [tb/dsr_host_model.sv]
// host side model: issues command bytes and clocks out reply bytes
`timescale 1ns/10ps
module dsr_host_model (
    input wire logic clk_sys, // system clock
    input wire logic rd_valid, // reply byte pending
    input wire logic [7:0] rd_data, // reply byte
    input wire logic updating, // register update window
    output logic cmd_valid, // command strobe
    output logic [7:0] cmd_code, // command byte
    output logic rd_strobe // read cycle
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        rd_strobe = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // code inverted once the strobe drops, so nothing may lean on a stale byte
    task automatic send_cmd(input logic [7:0] code);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_code = code;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_code = ~code;
    endtask : send_cmd
    // exactly n bytes, one strobe each, last byte lands in the low byte of w
    task automatic read_bytes(input int n, output logic [31:0] w);
        int i;
        int t;
        w = 32'h0;
        // the first byte stands only from the first edge after the command edge
        @(negedge clk_sys);
        for (i = 0; i < n; i++)
        begin
            t = 0;
            while (rd_valid !== 1'b1 && t < 8)
            begin
                @(negedge clk_sys);
                t++;
            end
            w = {w[23:0], (rd_valid === 1'b1) ? rd_data : 8'hXX};
            rd_strobe = 1'b1;
            @(negedge clk_sys);
            rd_strobe = 1'b0;
            // the next byte shows one edge after the strobe edge
            @(negedge clk_sys);
        end
    endtask : read_bytes
    // no further command until the update window has closed
    task automatic wait_update(output int len);
        int t;
        t = 0;
        len = 0;
        while (updating !== 1'b1 && t < 8)
        begin
            @(negedge clk_sys);
            t++;
        end
        while (updating === 1'b1 && len < 200)
        begin
            @(negedge clk_sys);
            len++;
        end
    endtask : wait_update
    // sleep-out is never sent by this host after a soft reset, so no 120 ms wait arises
endmodule : dsr_host_model

// [tb/testbench.sv]
// testbench: command decoder driven by the host model, all reads checked
`timescale 1ns/10ps
module testbench;
    localparam int UPD_CYC = 20;
    logic clk_sys, reset, cmd_valid, rd_strobe;
    logic [7:0] cmd_code, rd_data;
    logic [31:0] st, w;
    logic rd_valid, soft_reset_pulse, blank_display, sleep_in_state, updating, transfer_end;
    int err_total, check_count, n_sr, n_te, len;

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys)
    begin
        if (soft_reset_pulse === 1'b1) n_sr++;
        if (transfer_end === 1'b1) n_te++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // identification values are arbitrary
    dsr_command_decoder #(.UPDATE_CYCLES(UPD_CYC), .MAKER_ID(8'hA7), .MODULE_TYPE(1'b0),
        .VERSION_ID(7'h12), .MODULE_ID(8'h6D)) dsr_command_decoder_inst (
        .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .rd_strobe(rd_strobe), .booster_on(st[31]), .idle_on(st[19]), .partial_on(st[18]),
        .sleep_out(st[17]), .normal_on(st[16]), .vscroll_on(st[15]), .invert_on(st[13]),
        .all_on(st[12]), .all_off(st[11]), .display_on(st[10]), .tear_on(st[9]),
        .tear_mode(st[5]), .gamma_sel(st[8:6]), .access_ctrl(st[30:23]),
        .pixel_fmt(st[22:20]), .hsync_in(st[4]), .vsync_in(st[3]),
        .parallel_pixel_clock(st[2]), .parity_err(st[0]), .rd_data(rd_data),
        .rd_valid(rd_valid), .soft_reset_pulse(soft_reset_pulse),
        .blank_display(blank_display), .sleep_in_state(sleep_in_state),
        .updating(updating), .transfer_end(transfer_end));
    dsr_host_model dsr_host_model_inst (.clk_sys(clk_sys), .rd_valid(rd_valid),
        .rd_data(rd_data), .updating(updating), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .rd_strobe(rd_strobe));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_val
    task automatic finish_test();
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    // one read command and its reply bytes
    task automatic read_cmd(input logic [7:0] code, input int n);
        dsr_host_model_inst.send_cmd(code);
        dsr_host_model_inst.read_bytes(n, w);
    endtask : read_cmd
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_ident();
        read_cmd(dsr_pkg::CMD_READ_IDENT, 3);
        cmp_val("ident", 32'h00A7126D, w);
        cmp_val("valid_after", 32'h0, {31'h0, rd_valid});
    endtask : t_ident
    // every read with state s; sync lines flip right after the status command
    task automatic t_reads(input logic [31:0] s);
        st = s;
        read_cmd(dsr_pkg::CMD_READ_IDENT, 1);
        cmp_val("ident_cut", 32'h000000A7, w);
        dsr_host_model_inst.send_cmd(dsr_pkg::CMD_READ_STATUS);
        st[4:2] = ~s[4:2];
        dsr_host_model_inst.read_bytes(4, w);
        cmp_val("status", s & 32'hFFFFBFFD, w);
        cmp_val("status_low", {26'h0, s[5:2], 1'b0, s[0]}, {26'h0, w[5:0]});
        read_cmd(dsr_pkg::CMD_READ_POWER, 1);
        cmp_val("power", {25'h0, s[19], 1'b0, s[17:16], s[10], 2'h0}, w);
        read_cmd(dsr_pkg::CMD_READ_ACCESS, 1);
        cmp_val("access", {24'h0, s[30:29], 2'h0, s[26], 1'b0, s[24:23]}, w);
        read_cmd(dsr_pkg::CMD_READ_PIXFMT, 1);
        cmp_val("pixfmt", 32'h00000070, w);
    endtask : t_reads
    // no-operation: one end-of-transfer pulse, nothing else moves
    task automatic t_nop();
        int sr0;
        int te0;
        sr0 = n_sr;
        te0 = n_te;
        dsr_host_model_inst.send_cmd(dsr_pkg::CMD_NOP);
        read_cmd(dsr_pkg::CMD_READ_POWER, 1);
        cmp_val("nop_pulse", 32'h1, n_te - te0);
        cmp_val("nop_reset", 32'h0, n_sr - sr0);
        cmp_val("nop_power", {25'h0, st[19], 1'b0, st[17:16], st[10], 2'h0}, w);
        cmp_val("nop_blank", 32'h0, {30'h0, blank_display, sleep_in_state});
    endtask : t_nop
    // soft reset issued from sleep-in only
    task automatic t_soft_reset();
        int sr0;
        sr0 = n_sr;
        st[17] = 1'b0;
        dsr_host_model_inst.send_cmd(dsr_pkg::CMD_SOFT_RESET);
        @(negedge clk_sys);
        cmp_val("sr_pulse", 32'h1, n_sr - sr0);
        cmp_val("sr_blank", 32'h3, {30'h0, blank_display, sleep_in_state});
        dsr_host_model_inst.wait_update(len);
        cmp_val("update_len", UPD_CYC, len);
        st[17] = 1'b1;
        read_cmd(dsr_pkg::CMD_READ_STATUS, 4);
        cmp_val("sr_status", 32'h0, {30'h0, w[17], w[10]});
        cmp_val("sr_access", {24'h0, st[30:23]}, {24'h0, w[30:23]});
    endtask : t_soft_reset
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        err_total = 0;
        check_count = 0;
        n_sr = 0;
        n_te = 0;
        st = 32'h0;
        reset = 1'b1;
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        cmp_val("reset_out", 32'h6, {28'h0, rd_valid, blank_display, sleep_in_state, updating});
        t_ident();
        // any command other than NOP, soft reset or a read lifts the forced blank and sleep
        dsr_host_model_inst.send_cmd(8'h29);
        t_reads(32'hA5C35A3C);
        t_reads(32'h5A3CA5C3);
        t_nop();
        t_soft_reset();
        finish_test();
    end
    initial
    begin
        #200000;
        err_total++;
        finish_test();
    end
endmodule : testbench
